// File: hdl/vpd_map.svh
`ifndef VPD_MAP_SVH
`define VPD_MAP_SVH

// =============================================
// Port geometry
`define VPD_PINS 21
`define VPD_DATA_W 20
`define VPD_HALF_W 10
`define VPD_GPIO_W 23
`define VPD_CTL_LSB 20

// =============================================
// Buffer sizing and indexing
`define VPD_Y_BYTES 2560
`define VPD_C_BYTES 1280
`define VPD_FIFO_DEPTH 8
`define VPD_NBUF 4
`define VPD_BUF_Y 0
`define VPD_BUF_CB 1
`define VPD_BUF_CR 2
`define VPD_BUF_B 3

// =============================================
// Sampled pin vector layout
`define VPD_SMP_W 24
`define VPD_SMP_CLK 20

`endif

// File: hdl/vpd_pkg.sv
package vpd_pkg;

  // =============================================
  // Display modes
  typedef enum logic [2:0] {
    MODE_BT656,
    MODE_RAW8,
    MODE_RAWDUAL,
    MODE_RAW16,
    MODE_YC
  } vpd_mode_t;

  // =============================================
  // Control pin output source select
  typedef logic [1:0] vpd_ctl_sel_t;

endpackage : vpd_pkg

// File: hdl/vpd_fifo.sv
`timescale 1ns/1ps
module vpd_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic [WIDTH-1:0] outData_q;
  logic room_q;
  wire inFire = inValid & inReady;
  wire outFire = outValid & outReady;
  wire [AW-1:0] rdNext = outFire ? rdPtr_q + AW'(1) : rdPtr_q;
  wire bypass = inFire & (wrPtr_q == rdNext);

  wire [AW:0] countNext = count_q + (AW+1)'(inFire) - (AW+1)'(outFire);

  // Ready is kept in a flop so the port's ready output is registered
  assign inReady = room_q;
  assign outValid = (count_q != '0);
  assign outData = outData_q;

  // =============================================
  // Storage
  always_ff @(posedge sys_clk) begin
    if (inFire) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // =============================================
  // Registered head word with write bypass
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outData_q <= '0;
    end else begin
      outData_q <= bypass ? inData : mem[rdNext];
    end
  end

  // =============================================
  // Pointers and fill level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      room_q <= 1'b1;
    end else begin
      if (inFire) wrPtr_q <= wrPtr_q + AW'(1);
      rdPtr_q <= rdNext;
      count_q <= countNext;
      room_q <= (countNext != (AW+1)'(DEPTH));
    end
  end
endmodule : vpd_fifo

// File: hdl/vpd_display_port.sv
`timescale 1ns/1ps
`include "vpd_map.svh"
// Function
// - BT.656 drives channel A on low ten lines
// - BT.656 uses separate luma, blue, red buffers
// - 8/10-bit raw: one buffer, lower half bus
// - Locked raw: A and B share clock, controls
// - Locked raw: each channel own buffer, write
// - 16/20-bit raw: one buffer, full bus
// - Y/C: luma low, alternating chroma high
// - Y/C luma 2560 bytes, chroma 1280 each
// - FIFO write port separate, high-speed only
// - 21 pins, function follows mode
// - Unused pins may be GPIO, not clocks
// - Control one: horizontal timing out or in
// - Control two: vertical timing out or in
// - Control three: blanking/field out or in
// - Port is capture or display; B idle single
module vpd_display_port
  import vpd_pkg::*;
#(
  parameter int WIDTH = `VPD_DATA_W,
  parameter int DEPTH = `VPD_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic portEnable,
  input wire logic displayMode,
  input vpd_mode_t mode,
  input wire logic [2:0] ctlInMode,
  input vpd_ctl_sel_t ctl1Sel,
  input vpd_ctl_sel_t ctl2Sel,
  input vpd_ctl_sel_t ctl3Sel,
  input wire logic horizontal_sync,
  input wire logic horizontal_blank,
  input wire logic active_video_flag,
  input wire logic field_indicator,
  input wire logic vertical_sync,
  input wire logic vertical_blank,
  input wire logic composite_sync,
  input wire logic composite_blank,
  input wire logic [`VPD_GPIO_W-1:0] gpioEn,
  input wire logic [`VPD_GPIO_W-1:0] gpioOut,
  output logic [`VPD_GPIO_W-1:0] gpioIn,
  input wire logic [`VPD_NBUF-1:0] wrValid,
  input wire logic [WIDTH-1:0] wrData,
  output logic [`VPD_NBUF-1:0] wrReady,
  input wire logic port_clock_pin_one,
  input wire logic [`VPD_DATA_W-1:0] portDataIn,
  output logic [`VPD_DATA_W-1:0] portDataOut,
  output logic [`VPD_DATA_W-1:0] portDataOe,
  output logic port_clock_pin_two,
  output logic portClockTwoOe,
  input wire logic [2:0] controlPinIn,
  output logic [2:0] controlPinOut,
  output logic [2:0] controlPinOe,
  output logic extHsync,
  output logic extVsync,
  output logic extField,
  output logic underrun
);

  // =============================================
  // Helpers
  function automatic logic sel4(input logic [1:0] sel, input logic [3:0] src);
    sel4 = src[sel];
  endfunction : sel4

  function automatic int bufDepth(input int idx);
    if (idx == `VPD_BUF_CB || idx == `VPD_BUF_CR) begin
      bufDepth = DEPTH * `VPD_C_BYTES / `VPD_Y_BYTES;
    end else begin
      bufDepth = DEPTH;
    end
  endfunction : bufDepth

  // =============================================
  // Pin synchronisers
  logic [`VPD_SMP_W-1:0] smpA_q;
  logic [`VPD_SMP_W-1:0] smpB_q;
  logic clkPrev_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      smpA_q <= '0;
      smpB_q <= '0;
      clkPrev_q <= 1'b0;
    end else begin
      smpA_q <= {controlPinIn, port_clock_pin_one, portDataIn};
      smpB_q <= smpA_q;
      clkPrev_q <= smpB_q[`VPD_SMP_CLK];
    end
  end

  wire clkNow = smpB_q[`VPD_SMP_CLK];
  wire pixEdge = clkNow & ~clkPrev_q;
  wire [2:0] ctlSmp = smpB_q[`VPD_SMP_W-1:`VPD_SMP_CLK+1];

  // =============================================
  // Mode decode
  wire displayEn = portEnable & displayMode;
  wire isBt = (mode == MODE_BT656);
  wire isRaw8 = (mode == MODE_RAW8);
  wire isDual = (mode == MODE_RAWDUAL);
  wire isRaw16 = (mode == MODE_RAW16);
  wire isYc = (mode == MODE_YC);
  wire upperUsed = isDual | isRaw16 | isYc;

  // =============================================
  // Buffers, filled over the dedicated write port
  logic [`VPD_NBUF-1:0] bufValid;
  logic [`VPD_NBUF-1:0] bufPop;
  logic [`VPD_NBUF-1:0] bufPush;
  logic [WIDTH-1:0] bufData [`VPD_NBUF];

  // Channel B buffer accepts nothing outside locked raw
  assign bufPush = wrValid & {isDual, 3'b111};

  genvar gi;
  generate
    for (gi = 0; gi < `VPD_NBUF; gi++) begin : g_buf
      vpd_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(bufDepth(gi))
      ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(bufPush[gi]),
        .inReady(wrReady[gi]),
        .inData(wrData),
        .outValid(bufValid[gi]),
        .outReady(bufPop[gi]),
        .outData(bufData[gi])
      );
    end
  endgenerate

  // =============================================
  // Sample sequencing
  logic [1:0] btPhase_q;
  logic ycRed_q;
  logic [WIDTH-1:0] pixData_q;
  logic underrun_q;

  // BT.656 order: Cb, Y, Cr, Y
  wire btLuma = btPhase_q[0];
  wire btRed = btPhase_q[1];
  wire needY = isRaw8 | isDual | isRaw16 | isYc | (isBt & btLuma);
  wire needCb = (isBt & ~btLuma & ~btRed) | (isYc & ~ycRed_q);
  wire needCr = (isBt & ~btLuma & btRed) | (isYc & ycRed_q);
  wire needB = isDual;
  wire [`VPD_NBUF-1:0] need = {needB, needCr, needCb, needY};
  wire allReady = &(bufValid | ~need);
  wire run = displayEn & pixEdge;
  wire fire = run & allReady;

  assign bufPop = need & {`VPD_NBUF{fire}};

  wire [`VPD_HALF_W-1:0] yLow = bufData[`VPD_BUF_Y][`VPD_HALF_W-1:0];
  wire [`VPD_HALF_W-1:0] cbLow = bufData[`VPD_BUF_CB][`VPD_HALF_W-1:0];
  wire [`VPD_HALF_W-1:0] crLow = bufData[`VPD_BUF_CR][`VPD_HALF_W-1:0];
  wire [`VPD_HALF_W-1:0] bLow = bufData[`VPD_BUF_B][`VPD_HALF_W-1:0];
  wire [`VPD_HALF_W-1:0] btWord = btLuma ? yLow : (btRed ? crLow : cbLow);
  wire [`VPD_HALF_W-1:0] lowNext = isBt ? btWord : yLow;
  wire [`VPD_HALF_W-1:0] ycChroma = ycRed_q ? crLow : cbLow;
  wire [`VPD_HALF_W-1:0] hiNext =
    isRaw16 ? bufData[`VPD_BUF_Y][WIDTH-1:`VPD_HALF_W] :
    isYc ? ycChroma :
    isDual ? bLow :
    '0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      btPhase_q <= '0;
      ycRed_q <= 1'b0;
      pixData_q <= '0;
      underrun_q <= 1'b0;
    end else begin
      underrun_q <= run & ~allReady;
      if (!displayEn) begin
        btPhase_q <= '0;
        ycRed_q <= 1'b0;
      end else if (fire) begin
        pixData_q <= {hiNext, lowNext};
        btPhase_q <= isBt ? btPhase_q + 2'd1 : 2'd0;
        ycRed_q <= isYc ? ~ycRed_q : 1'b0;
      end
    end
  end

  // =============================================
  // Pin drive
  wire [`VPD_DATA_W-1:0] dataUsed =
    displayEn ? {{`VPD_HALF_W{upperUsed}}, {`VPD_HALF_W{1'b1}}} : '0;
  wire [`VPD_DATA_W-1:0] dataGpioEn = gpioEn[`VPD_DATA_W-1:0] & ~dataUsed;
  wire [`VPD_DATA_W-1:0] dataOeNext = dataUsed | dataGpioEn;
  wire [`VPD_DATA_W-1:0] dataOutNext =
    (pixData_q & dataUsed) | (gpioOut[`VPD_DATA_W-1:0] & ~dataUsed);

  wire [3:0] ctl1Src = {field_indicator, active_video_flag, horizontal_blank, horizontal_sync};
  wire [3:0] ctl2Src = {field_indicator, composite_sync, vertical_blank, vertical_sync};
  wire [3:0] ctl3Src = {field_indicator, field_indicator, field_indicator, composite_blank};
  wire [2:0] ctlTiming = {sel4(ctl3Sel, ctl3Src),
                          sel4(ctl2Sel, ctl2Src),
                          sel4(ctl1Sel, ctl1Src)};
  wire [2:0] ctlGpioEn = gpioEn[`VPD_GPIO_W-1:`VPD_CTL_LSB];
  wire [2:0] ctlGpioOut = gpioOut[`VPD_GPIO_W-1:`VPD_CTL_LSB];
  wire [2:0] ctlOeNext = displayEn ? ~ctlInMode : ctlGpioEn;
  wire [2:0] ctlOutNext = displayEn ? (ctlTiming & ~ctlInMode) : ctlGpioOut;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portDataOut <= '0;
      portDataOe <= '0;
      controlPinOut <= '0;
      controlPinOe <= '0;
      port_clock_pin_two <= 1'b0;
      portClockTwoOe <= 1'b0;
    end else begin
      portDataOut <= dataOutNext;
      portDataOe <= dataOeNext;
      controlPinOut <= ctlOutNext;
      controlPinOe <= ctlOeNext;
      // Pixel clock echoed on pin two; never a GPIO
      port_clock_pin_two <= clkNow & displayEn;
      portClockTwoOe <= displayEn;
    end
  end

  // =============================================
  // Inputs seen by the rest of the port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpioIn <= '0;
      extHsync <= 1'b0;
      extVsync <= 1'b0;
      extField <= 1'b0;
      underrun <= 1'b0;
    end else begin
      gpioIn <= {ctlSmp, smpB_q[`VPD_DATA_W-1:0]};
      extHsync <= displayEn & ctlInMode[0] & ctlSmp[0];
      extVsync <= displayEn & ctlInMode[1] & ctlSmp[1];
      extField <= displayEn & ctlInMode[2] & ctlSmp[2];
      underrun <= underrun_q;
    end
  end

endmodule : vpd_display_port

// File: test/vpd_display_port_chk.sv
`timescale 1ns/1ps
`include "vpd_map.svh"
module vpd_display_port_chk
  import vpd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic portEnable,
  input wire logic displayMode,
  input wire vpd_mode_t mode,
  input wire logic [2:0] ctlInMode,
  input wire vpd_ctl_sel_t ctl1Sel,
  input wire logic horizontal_sync,
  input wire logic port_clock_pin_one,
  input wire logic port_clock_pin_two,
  input wire logic [`VPD_GPIO_W-1:0] gpioEn,
  input wire logic [`VPD_DATA_W-1:0] portDataOe,
  input wire logic portClockTwoOe,
  input wire logic [2:0] controlPinIn,
  input wire logic [2:0] controlPinOut,
  input wire logic [2:0] controlPinOe,
  input wire logic extHsync
);
  // ==========
  // Pin drive checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic dispOn = portEnable && displayMode;
  wire logic wide = mode inside {MODE_RAWDUAL, MODE_RAW16, MODE_YC};
  wire logic hiFree = gpioEn[19:10] == 10'h000;
  wire logic [19:0] gpioDataEn = gpioEn[19:0];
  sequence s_disp; dispOn [*2]; endsequence
  sequence s_wide; (dispOn && wide) [*2]; endsequence
  sequence s_narrow; (dispOn && !wide && hiFree) [*2]; endsequence
  sequence s_slave; (dispOn && ctlInMode[0] && controlPinIn[0]) [*5]; endsequence
  property p_cap_gpio; !displayMode |=> portDataOe == $past(gpioDataEn); endproperty
  a_cap_gpio: assert property (p_cap_gpio) else $error("capture drive not gpio");
  property p_clk2_off; !displayMode |=> !portClockTwoOe; endproperty
  a_clk2_off: assert property (p_clk2_off) else $error("clock two driven");
  property p_clk2_echo;
    dispOn |=> port_clock_pin_two == $past(port_clock_pin_one, 3);
  endproperty
  a_clk2_echo: assert property (p_clk2_echo) else $error("clock two not echoed");
  property p_low_oe; s_disp |=> &portDataOe[9:0]; endproperty
  a_low_oe: assert property (p_low_oe) else $error("low half not driven");
  property p_narrow; s_narrow |=> portDataOe[19:10] == 10'h000; endproperty
  a_narrow: assert property (p_narrow) else $error("upper half driven");
  property p_wide; s_wide |=> &portDataOe[19:10]; endproperty
  a_wide: assert property (p_wide) else $error("upper half not driven");
  property p_ctl_oe; s_disp |=> controlPinOe == ~$past(ctlInMode); endproperty
  a_ctl_oe: assert property (p_ctl_oe) else $error("control direction wrong");
  property p_ctl1; s_disp ##0 (!ctlInMode[0] && ctl1Sel == 2'h0)
    |=> controlPinOut[0] == $past(horizontal_sync); endproperty
  a_ctl1: assert property (p_ctl1) else $error("control one not hsync");
  property p_slave; s_slave |=> extHsync; endproperty
  a_slave: assert property (p_slave) else $error("slave hsync lost");
endmodule : vpd_display_port_chk

bind vpd_display_port vpd_display_port_chk u_vpd_display_port_chk (.sys_clk, .rst,
  .portEnable, .displayMode, .mode, .ctlInMode, .ctl1Sel, .horizontal_sync,
  .port_clock_pin_one, .port_clock_pin_two, .gpioEn,
  .portDataOe, .portClockTwoOe, .controlPinIn, .controlPinOut, .controlPinOe, .extHsync);

// File: test/vpd_pixel_sink.sv
`timescale 1ns/1ps
module vpd_pixel_sink (
  output logic port_clock_pin_one,
  input wire logic [19:0] portDataOut,
  input wire logic [19:0] portDataOe,
  output logic [19:0] portDataIn,
  input wire logic [2:0] controlPinOut,
  input wire logic [2:0] controlPinOe,
  input wire logic [2:0] extCtl,
  output logic [2:0] controlPinIn
);
  // ==========
  // Pins; released data lines show the capture source, else the inverse of the drive
  logic [19:0] srcData = 20'h00000;
  logic srcOn = 1'b0;
  logic [19:0] got[$];
  wire [19:0] idleData = srcOn ? srcData : ~portDataOut;
  assign portDataIn = (portDataOe & portDataOut) | (~portDataOe & idleData);
  assign controlPinIn = (controlPinOe & controlPinOut) | (~controlPinOe & extCtl);
  initial port_clock_pin_one = 1'b0;
  // Capture source: drives the data lines whenever the port releases them
  task automatic source(input logic [19:0] d);
    srcData = d;
    srcOn = 1'b1;
  endtask : source
  // Clock only inside a frame; each rising edge latches the driven lines
  task automatic frame(input int n);
    got.delete();
    #3;
    repeat (n) begin
      #80;
      port_clock_pin_one = 1'b1;
      got.push_back(portDataOut & portDataOe);
      #80;
      port_clock_pin_one = 1'b0;
    end
  endtask : frame
endmodule : vpd_pixel_sink

// File: test/vpd_display_port_test.sv
`timescale 1ns/1ps
`include "vpd_map.svh"
module vpd_display_port_test
  import vpd_pkg::*;
;
  logic sys_clk, rst, portEnable, displayMode;
  vpd_mode_t mode;
  logic [2:0] ctlInMode, extCtl, controlPinIn, controlPinOut, controlPinOe;
  vpd_ctl_sel_t ctl1Sel, ctl2Sel, ctl3Sel;
  logic [7:0] tim;
  logic horizontal_sync, horizontal_blank, active_video_flag, field_indicator;
  logic vertical_sync, vertical_blank, composite_sync, composite_blank;
  logic [22:0] gpioEn, gpioOut, gpioIn;
  logic [3:0] wrValid, wrReady;
  logic [19:0] wrData, portDataIn, portDataOut, portDataOe;
  logic port_clock_pin_one, port_clock_pin_two, portClockTwoOe;
  logic extHsync, extVsync, extField, underrun;
  int errors, cmp_count;
  int underruns = 0;
  assign {horizontal_sync, horizontal_blank, active_video_flag, field_indicator} = tim[7:4];
  assign {vertical_sync, vertical_blank, composite_sync, composite_blank} = tim[3:0];
  vpd_display_port u_vpd_display_port (.sys_clk, .rst, .portEnable, .displayMode, .mode,
    .ctlInMode, .ctl1Sel, .ctl2Sel, .ctl3Sel, .horizontal_sync, .horizontal_blank,
    .active_video_flag, .field_indicator, .vertical_sync, .vertical_blank, .composite_sync,
    .composite_blank, .gpioEn, .gpioOut, .gpioIn, .wrValid, .wrData, .wrReady,
    .port_clock_pin_one, .portDataIn, .portDataOut, .portDataOe, .port_clock_pin_two,
    .portClockTwoOe, .controlPinIn, .controlPinOut, .controlPinOe, .extHsync, .extVsync,
    .extField, .underrun);
  vpd_pixel_sink u_vpd_pixel_sink (.port_clock_pin_one, .portDataOut, .portDataOe,
    .portDataIn, .controlPinOut, .controlPinOe, .extCtl, .controlPinIn);
  // ==========
  // Helpers
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (underrun === 1'b1) underruns++;
  end
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic reset_dut;
    rst = 1'b1;
    wrValid = '0;
    displayMode = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    chk(portDataOe, 20'h00000);
  endtask : reset_dut
  // Caller stands at a falling edge; valid is left up for back-to-back words
  task automatic wr(input int b, input logic [19:0] w);
    wrValid = 4'(1 << b);
    wrData = w;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : wr
  // ==========
  // Scenarios
  task automatic t_depth(input int b, input int depth);
    int n;
    n = 0;
    while (wrReady[b] === 1'b1 && n < 12) begin
      wr(b, 20'h00055);
      n++;
    end
    wrValid = '0;
    chk(20'(n), 20'(depth));
  endtask : t_depth
  task automatic t_play(input vpd_mode_t m, input logic [23:0] w[$], input logic [19:0] e[$]);
    int base;
    mode = m;
    foreach (w[k]) wr(w[k][23:20], w[k][19:0]);
    wrValid = '0;
    displayMode = 1'b1;
    repeat (3) @(negedge sys_clk);
    e.push_back(e[$]);
    base = underruns;
    u_vpd_pixel_sink.frame(e.size() + 1);
    @(negedge sys_clk);
    foreach (e[k]) chk(u_vpd_pixel_sink.got[k + 1], e[k]);
    // Two pixel edges beyond the last word find the buffers empty
    chk(20'(underruns - base), 20'h00002);
    reset_dut();
  endtask : t_play
  task automatic t_ctl;
    displayMode = 1'b1;
    tim = 8'h94;
    for (int s = 0; s < 4; s++) begin
      ctl1Sel = 2'(s);
      ctl2Sel = 2'(s);
      ctl3Sel = 2'(s);
      repeat (3) @(negedge sys_clk);
      chk(20'(controlPinOut), 20'((12'hF31 >> (3 * s)) & 12'h007));
    end
    chk(20'(controlPinOe), 20'h00007);
    ctlInMode = 3'h7;
    extCtl = 3'h5;
    repeat (6) @(negedge sys_clk);
    chk(20'({controlPinOe, extField, extVsync, extHsync}), 20'h00005);
    ctlInMode = 3'h0;
    reset_dut();
  endtask : t_ctl
  // Capture: the port releases its pins and reads the source through GPIO inputs
  task automatic t_capture;
    portEnable = 1'b0;
    displayMode = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(portDataOe, 20'h00000);
    chk(20'({portClockTwoOe, controlPinOe}), 20'h00000);
    portEnable = 1'b1;
    displayMode = 1'b0;
    u_vpd_pixel_sink.source(20'h2AD55);
    extCtl = 3'h3;
    repeat (4) @(negedge sys_clk);
    chk(20'(gpioIn[22:20]), 20'h00003);
    chk(20'(gpioIn[19:0]), 20'h2AD55);
    chk(20'(portClockTwoOe), 20'h00000);
    u_vpd_pixel_sink.source(20'h000A7);
    extCtl = 3'h6;
    repeat (4) @(negedge sys_clk);
    chk(20'(gpioIn[19:0]), 20'h000A7);
    chk(20'(gpioIn[22:20]), 20'h00006);
    extCtl = 3'h4;
    repeat (4) @(negedge sys_clk);
    chk(20'(gpioIn[22:20]), 20'h00004);
    extCtl = 3'h0;
  endtask : t_capture
  task automatic t_gpio;
    gpioEn = 23'h7FFFFF;
    gpioOut = 23'h05A5A5;
    repeat (6) @(negedge sys_clk);
    chk(portDataOe, 20'hFFFFF);
    chk(20'(gpioIn), 20'h5A5A5);
    chk(20'(portClockTwoOe), 20'h00000);
    gpioEn = '0;
  endtask : t_gpio
  initial begin
    portEnable = 1'b1;
    mode = MODE_BT656;
    {ctlInMode, extCtl, ctl1Sel, ctl2Sel, ctl3Sel, tim} = '0;
    {gpioEn, gpioOut, wrData} = '0;
    errors = 0;
    cmp_count = 0;
    reset_dut();
    t_depth(3, 12);
    t_depth(0, 8);
    t_depth(1, 4);
    t_depth(2, 4);
    mode = MODE_RAWDUAL;
    t_depth(3, 8);
    reset_dut();
    t_play(MODE_BT656, '{24'h1AB011, 24'h000022, 24'h200033, 24'h000044},
      '{20'h00011, 20'h00022, 20'h00033, 20'h00044});
    t_play(MODE_RAW8, '{24'h0FFC55}, '{20'h00055});
    t_play(MODE_RAW16, '{24'h0ABCDE}, '{20'hABCDE});
    t_play(MODE_YC, '{24'h000101, 24'h000102, 24'h100201, 24'h200301},
      '{20'h80501, 20'hC0502});
    t_play(MODE_RAWDUAL, '{24'h000155, 24'h3002AA}, '{20'hAA955});
    t_ctl();
    t_capture();
    t_gpio();
    complete_run();
  end
  // Whole run takes well under 60 us
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : vpd_display_port_test
